// ### i2c_master_model.sv
// Behavioural two-wire bus master, about 48 ns per clock bit.
// Assumes pulled-up wires; the bench resolves them from all drivers.
module i2c_master_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_lo,
  output logic      sda_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  task automatic start();
    sda_lo <= 1'b1;
    #24;
    scl_lo <= 1'b1;
    #4;
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_lo <= !b;
    #20;
    scl_lo <= 1'b0;
    // Waiting on the wire honours slave clock stretching
    wait (scl === 1'b1);
    #24;
    r = sda;
    scl_lo <= 1'b1;
    #4;
  endtask
  task automatic xfer(input logic [7:0] d, input logic b9,
                      output logic [7:0] q, output logic r9);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(b9, r9);
  endtask
  task automatic stop();
    sda_lo <= 1'b1;
    #20;
    scl_lo <= 1'b0;
    wait (scl === 1'b1);
    #24;
    sda_lo <= 1'b0;
    #24;
  endtask
endmodule

// ### i2c_slave_tx.sv
// Two-wire slave with automatic switch to transmit on a read address.
// Assumes an external master clocks SCL; registers over AHB-Lite.
// Operation
// - Matched address acked with configured level
// - Read bit sets transmit select automatically
// - Shift transmit data; master clocks, acknowledges
// - Clear select, dummy read releases SCL
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
module i2c_slave_tx
  import i2c_slave_tx_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_in,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_oe,
  output logic             irq
);
  import i2c_slave_tx_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] pins_s;
  sync2 #(.W(2)) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({scl_in, sda_in}),
    .q     (pins_s)
  );
  logic scl_s;
  logic sda_s;
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic              scl_d, sda_d;
  logic [CTRL_W-1:0] ctrl, next_ctrl;
  logic [ST_W-1:0]   status, next_status;
  logic [ST_W-1:0]   mask, next_mask;
  logic [7:0]        txdata, next_txdata;
  logic [7:0]        rxdata, next_rxdata;
  logic [6:0]        own, next_own;
  logic [7:0]        shreg, next_shreg;
  logic [3:0]        bitcnt, next_bitcnt;
  link_state_e       lstate, next_lstate;
  logic              hold_scl, next_hold_scl;
  logic              next_scl_oe, next_sda_oe, next_irq;
  logic              ph_valid, next_ph_valid;
  logic              ph_write, next_ph_write;
  logic [7:0]        ph_addr, next_ph_addr;
  logic [31:0]       next_hrdata;

  // ----------------------------------------------------------------------
  // Pin edges
  // ----------------------------------------------------------------------
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  // Only start and stop may move SDA while SCL is high
  assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------------
  logic ahb_go;
  assign ahb_go = hsel & htrans[1] & hready;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic wr, rd, en, ld_tx;
    logic [ST_W-1:0] set_ev, clr_w;
    wr = ph_valid & ph_write;
    rd = ph_valid & ~ph_write;
    en = ctrl[CTRL_ENABLE];
    ld_tx = 1'b0;
    set_ev = '0;
    clr_w = '0;
    next_ctrl     = ctrl;
    next_mask     = mask;
    next_txdata   = txdata;
    next_rxdata   = rxdata;
    next_own      = own;
    next_shreg    = shreg;
    next_bitcnt   = bitcnt;
    next_lstate   = lstate;
    next_hold_scl = hold_scl;
    next_sda_oe   = sda_oe;
    // Capture the address phase for the data-phase write
    next_ph_valid = ahb_go;
    next_ph_write = hwrite;
    next_ph_addr  = haddr[7:0];
    next_hrdata   = hrdata;

    // Register writes (data phase)
    if (wr) begin
      case (ph_addr)
        ADDR_CTRL:   next_ctrl = hwdata[CTRL_W-1:0];
        ADDR_MASK:   next_mask = hwdata[ST_W-1:0];
        ADDR_OWN:    next_own  = hwdata[6:0];
        ADDR_STATUS: clr_w     = hwdata[ST_W-1:0];
        ADDR_TXDATA: begin
          next_txdata = hwdata[7:0];
          ld_tx = 1'b1;
        end
        default: ;
      endcase
    end
    if (rd && ph_addr == ADDR_RXDATA && !ctrl[CTRL_TRS]) begin
      next_hold_scl = 1'b0;
    end

    // Link sequencer, advancing on synchronised SCL edges
    if (!en) begin
      next_lstate   = LK_IDLE;
      next_sda_oe   = 1'b0;
      next_hold_scl = 1'b0;
    end else if (stop_c) begin
      next_lstate = LK_IDLE;
      next_sda_oe = 1'b0;
      set_ev[ST_STOP] = 1'b1;
    end else if (start_c) begin
      next_lstate = LK_ADDR;
      next_bitcnt = '0;
      next_sda_oe = 1'b0;
    end else begin
      case (lstate)
        LK_ADDR: begin
          if (scl_rise) begin
            next_shreg  = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end
          if (scl_fall && bitcnt == BITS_PER_BYTE) begin
            if (shreg[7:1] == own && !ctrl[CTRL_MST]) begin
              next_sda_oe = ~ctrl[CTRL_ACKLVL];
              next_lstate = LK_AACK;
              set_ev[ST_AAS] = 1'b1;
              if (shreg[0]) begin
                next_ctrl[CTRL_TRS] = 1'b1;
              end
            end else begin
              next_lstate = LK_IDLE;
            end
          end
        end
        LK_AACK, LK_MACK, LK_RACK: begin
          if (scl_fall) begin
            next_bitcnt = '0;
            next_sda_oe = 1'b0;
            // Delayed SDA avoids racing the master's next bit
            if (lstate == LK_MACK && sda_d) begin
              next_lstate = LK_IDLE;
            end else if (ctrl[CTRL_TRS]) begin
              next_lstate = LK_TX;
              next_shreg  = next_txdata;
              next_sda_oe = ~next_txdata[7];
              if (status[ST_TRANSMIT_EMPTY_FLAG] && !ld_tx && lstate != LK_AACK) begin
                next_hold_scl = 1'b1;
                set_ev[ST_TRANSMIT_END_FLAG] = 1'b1;
              end
              set_ev[ST_TRANSMIT_EMPTY_FLAG] = 1'b1;
            end else begin
              next_lstate = LK_RX;
            end
          end
        end
        LK_TX: begin
          // Data written during a stretch replaces the stale shifter
          if (ld_tx && hold_scl) begin
            next_shreg      = next_txdata;
            next_sda_oe     = ~next_txdata[7];
            set_ev[ST_TRANSMIT_EMPTY_FLAG] = 1'b1;
          end
          if (scl_rise) begin
            next_bitcnt = bitcnt + 4'h1;
          end
          if (scl_fall) begin
            if (bitcnt == BITS_PER_BYTE) begin
              next_sda_oe = 1'b0;
              next_lstate = LK_MACK;
            end else begin
              next_shreg  = {shreg[6:0], 1'b0};
              next_sda_oe = ~shreg[6];
            end
          end
        end
        LK_RX: begin
          if (scl_rise) begin
            next_shreg  = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end
          if (scl_fall && bitcnt == BITS_PER_BYTE) begin
            next_rxdata = shreg;
            next_sda_oe = ~ctrl[CTRL_ACKLVL];
            next_lstate = LK_RACK;
          end
        end
        default: next_lstate = LK_IDLE;
      endcase
    end

    // Sticky flags: hardware set wins over write-one clear
    next_status = (status & ~clr_w) | set_ev;
    if (ld_tx && !set_ev[ST_TRANSMIT_EMPTY_FLAG]) begin
      next_status[ST_TRANSMIT_EMPTY_FLAG] = 1'b0;
    end

    // Stretch on underrun at a data byte's acknowledge; loading data also resumes
    if (ld_tx) begin
      next_hold_scl = 1'b0;
    end
    next_scl_oe = next_hold_scl & ~scl_s;
    next_irq    = |(next_status & mask);

    // Read data is registered here so it stands in the data phase
    if (ahb_go && !hwrite) begin
      case (haddr[7:0])
        ADDR_CTRL:   next_hrdata = {{(32-CTRL_W){1'b0}}, next_ctrl};
        ADDR_STATUS: next_hrdata = {{(32-ST_W){1'b0}}, next_status};
        ADDR_MASK:   next_hrdata = {{(32-ST_W){1'b0}}, next_mask};
        ADDR_TXDATA: next_hrdata = {24'h0, next_txdata};
        ADDR_RXDATA: next_hrdata = {24'h0, next_rxdata};
        ADDR_OWN:    next_hrdata = {25'h0, next_own};
        default:     next_hrdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_d     <= 1'b1;
      sda_d     <= 1'b1;
      ctrl      <= '0;
      status    <= ST_RESET;
      mask      <= '0;
      txdata    <= 8'h0;
      rxdata    <= 8'h0;
      own       <= OWN_ADDR_RESET;
      shreg     <= 8'h0;
      bitcnt    <= 4'h0;
      lstate    <= LK_IDLE;
      hold_scl  <= 1'b0;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
      irq       <= 1'b0;
      ph_valid  <= 1'b0;
      ph_write  <= 1'b0;
      ph_addr   <= 8'h0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      scl_d     <= scl_s;
      sda_d     <= sda_s;
      ctrl      <= next_ctrl;
      status    <= next_status;
      mask      <= next_mask;
      txdata    <= next_txdata;
      rxdata    <= next_rxdata;
      own       <= next_own;
      shreg     <= next_shreg;
      bitcnt    <= next_bitcnt;
      lstate    <= next_lstate;
      hold_scl  <= next_hold_scl;
      scl_oe    <= next_scl_oe;
      sda_oe    <= next_sda_oe;
      irq       <= next_irq;
      ph_valid  <= next_ph_valid;
      ph_write  <= next_ph_write;
      ph_addr   <= next_ph_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule

// ### i2c_slave_tx_pkg.sv
// Constants for the two-wire slave transmit sequencer.
// Assumes a single AHB-Lite slave port clocked by hclk.
package i2c_slave_tx_pkg;
  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0c;
  localparam logic [7:0] ADDR_RXDATA = 8'h10;
  localparam logic [7:0] ADDR_OWN    = 8'h14;
  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_TRS    = 1;
  localparam int CTRL_MST    = 2;
  localparam int CTRL_ACKLVL = 3;
  localparam int CTRL_MLS    = 4;
  localparam int CTRL_WAIT   = 5;
  localparam int CTRL_CKS_LO = 8;
  localparam int CTRL_W      = 12;
  // ----------------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------------
  localparam int ST_TRANSMIT_EMPTY_FLAG = 0;
  localparam int ST_TRANSMIT_END_FLAG = 1;
  localparam int ST_AAS  = 2;
  localparam int ST_STOP = 3;
  localparam int ST_W    = 4;
  localparam logic [ST_W-1:0] ST_RESET = 4'h1;
  localparam logic [6:0] OWN_ADDR_RESET = 7'h2a;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0] ACK_SLOT       = 4'h9;
  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_AACK, LK_TX, LK_MACK, LK_RX, LK_RACK
  } link_state_e;
endpackage

// ### i2c_slave_tx_properties.sv
// Port checker for the two-wire slave transmit sequencer.
// Assumes one hclk domain; bound to i2c_slave_tx below.
module i2c_slave_tx_checker
  import i2c_slave_tx_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        scl_in,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_oe,
  input wire logic        irq
);
  logic acc;
  assign acc = hsel && htrans[1] && hready
    && (haddr[7:0] == ADDR_RXDATA || haddr[7:0] == ADDR_TXDATA);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------------
  // Properties
  // ------------------
  sequence s_scl_high;
    scl_in [*6];
  endsequence
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("bus answer not zero wait OKAY");
  property p_sda_hold;
    s_scl_high |-> $stable(sda_oe);
  endproperty
  a_sda_hold: assert property (p_sda_hold)
    else $error("data line changed while clock high");
  property p_sda_rise;
    $rose(sda_oe) |-> $past(!scl_in);
  endproperty
  a_sda_rise: assert property (p_sda_rise)
    else $error("data line pulled while clock high");
  property p_stretch;
    $rose(scl_oe) |-> $past(!scl_in);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock stretch began while clock high");
  property p_release;
    $fell(scl_oe) |-> $past(acc) || $past(acc, 2) || $past(acc, 3);
  endproperty
  a_release: assert property (p_release)
    else $error("clock released without data access");
endmodule
bind i2c_slave_tx i2c_slave_tx_checker i2c_slave_tx_checker_inst (.*);

// ### sync2.sv
// Two flip-flop synchroniser for a vector of pin levels.
// Assumes inputs are asynchronous to clk.
module sync2 #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  // Idle bus lines are high, so reset to one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ### tb.sv
// Self-checking bench for the two-wire slave transmit sequencer.
// Assumes the master model and checker are compiled before it.
module tb;
  import i2c_slave_tx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        scl_oe, sda_oe, irq, m_scl, m_sda;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic   scl_in, sda_in;
  int          n_errors = 0, comparisons = 0, cyc = 0;
  localparam logic [31:0] CFG = 32'h0000_0f31;
  assign scl_in = !(m_scl || scl_oe);
  assign sda_in = !(m_sda || sda_oe);
  assign hready = hreadyout;
  i2c_slave_tx i2c_slave_tx_inst (.*);
  i2c_master_model i2c_master_model_inst (.scl(scl_in), .sda(sda_in),
    .scl_lo(m_scl), .sda_lo(m_sda));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite} <= {1'b1, 2'b10, w};
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans} <= 3'b000;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask
  task automatic poll(input logic [31:0] m);
    for (int i = 0; i < 3000; i++) begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      if ((rd & m) === m) break;
    end
    cmp(rd & m, m);
  endtask
  // ------------------
  // Scenarios
  // ------------------
  task automatic t_regs();
    rchk(ADDR_STATUS, {28'h0, ST_RESET});
    rchk(ADDR_OWN, {25'h0, OWN_ADDR_RESET});
    rchk(8'h20, 32'h0);
    bus(1'b1, ADDR_MASK, 32'h1);
    repeat (2) @(posedge hclk);
    cmp(irq, 1'b1);
    bus(1'b1, ADDR_STATUS, 32'h1);
    repeat (2) @(posedge hclk);
    cmp(irq, 1'b0);
    bus(1'b1, ADDR_MASK, 32'h0);
  endtask
  task automatic t_nack();
    logic [7:0] q;
    logic       r;
    bus(1'b1, ADDR_CTRL, CFG | 32'h8);
    rchk(ADDR_CTRL, CFG | 32'h8);
    i2c_master_model_inst.start();
    i2c_master_model_inst.xfer({OWN_ADDR_RESET, 1'b0}, 1'b1, q, r);
    cmp(r, 1'b1);
    i2c_master_model_inst.stop();
    rchk(ADDR_CTRL, CFG | 32'h8);
    bus(1'b1, ADDR_STATUS, 32'hf);
  endtask
  task automatic t_read();
    logic [7:0] q;
    logic       r;
    bus(1'b1, ADDR_CTRL, CFG);
    bus(1'b1, ADDR_TXDATA, 32'ha5);
    fork
      begin
        i2c_master_model_inst.start();
        i2c_master_model_inst.xfer({OWN_ADDR_RESET, 1'b1}, 1'b1, q, r);
        cmp(r, 1'b0);
        i2c_master_model_inst.xfer(8'hff, 1'b0, q, r);
        cmp(q, 8'ha5);
        i2c_master_model_inst.xfer(8'hff, 1'b0, q, r);
        cmp(q, 8'h3c);
        i2c_master_model_inst.xfer(8'hff, 1'b0, q, r);
        cmp(q, 8'h5a);
        i2c_master_model_inst.xfer(8'hff, 1'b1, q, r);
        i2c_master_model_inst.stop();
      end
      begin
        poll(32'h1);
        rchk(ADDR_CTRL, CFG | 32'h2);
        bus(1'b1, ADDR_TXDATA, 32'h3c);
        poll(32'h3);
        cmp(scl_oe, 1'b1);
        bus(1'b1, ADDR_STATUS, 32'h2);
        bus(1'b1, ADDR_TXDATA, 32'h5a);
        poll(32'h3);
        cmp(scl_oe, 1'b1);
        bus(1'b1, ADDR_STATUS, 32'h2);
        bus(1'b1, ADDR_CTRL, CFG);
        bus(1'b0, ADDR_RXDATA, 32'h0);
        repeat (4) @(posedge hclk);
        cmp(scl_oe, 1'b0);
        bus(1'b1, ADDR_STATUS, 32'h1);
        bus(1'b0, ADDR_STATUS, 32'h0);
        cmp(rd & 32'h3, 32'h0);
      end
    join
    rchk(ADDR_CTRL, CFG);
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // A hang in a handshake wait ends here instead of running forever
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_nack();
    t_read();
    give_verdict();
  end
endmodule
